// file: include/ato_pkg.sv
// Package of constants for the async turn-on override block
package ato_pkg;
   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS_WORD_ONE = 8'h04;
   localparam logic [7:0] OFS_STATUS_WORD_FOUR = 8'h08;

   // Control register fields
   localparam int unsigned CTL_DESATURATION_DETECT_EN_BIT = 0;
   localparam int unsigned CTL_SENSE_EN_BIT = 1;
   localparam int unsigned CTL_VH_UVLO_EN_BIT = 2;
   localparam int unsigned CTL_W = 3;
   localparam logic [2:0] CTL_RESET = 3'h7;

   // Status word one fields
   localparam int unsigned ST1_DESATURATION_DETECT_FLAG_BIT = 0;
   localparam int unsigned ST1_OC_FLAG_BIT = 1;

   // Status word four fields
   localparam int unsigned ST4_ASYNC_LEVEL_BIT = 0;
   localparam int unsigned ST4_OVERRIDE_ON_BIT = 1;
   localparam int unsigned ST4_TRIPPED_BIT = 2;
   localparam int unsigned ST4_REARM_PEND_BIT = 3;

   // Pre-driver levels: both low turns the external switch on
   localparam logic [1:0] DRIVE_SWITCH_ON = 2'h0;
   localparam logic [1:0] DRIVE_SWITCH_OFF = 2'h3;

   // Override state machine, one-hot
   typedef enum logic [2:0] {
      ATO_IDLE = 3'b001,
      ATO_ON = 3'b010,
      ATO_TRIP = 3'b100
   } ato_state_t;
endpackage

// file: rtl/ato_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module ato_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Level in and out
   input wire logic din,
   output logic dout
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule
`default_nettype wire

// file: rtl/ato_top.sv
// Async turn-on override logic of the high-voltage side driver
//
// Summary of operation
// - Async input high forces switch on
// - Works without primary logic supply present
// - Primary side faults never affect override
// - Needs both HV supplies up, started
// - Safe state drives outputs low, overrides
// - Positive supply undervoltage or range gating
// - Inhibited by overvoltage or thermal shutdown
// - Protection event turns off, sets flag
// - Only fresh rising edge re-enables after trip
// - Flag clear keeps present switch state
// - Override works in configuration mode too
// - Input level mirrored in status word four
`timescale 1ns/10ps
`default_nettype none
module ato_top (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Controller inputs
   input wire logic async_turn_on_input,
   input wire logic shutdown_input,
   input wire logic in_plus,
   input wire logic in_minus,
   input wire logic flag_clear_operation,
   input wire logic config_mode,
   // High-voltage side supply and thermal conditions
   input wire logic positive_gate_supply_present,
   input wire logic isolated_regulator_supply_present,
   input wire logic hv_startup_done,
   input wire logic positive_gate_supply_uvlo,
   input wire logic positive_gate_supply_in_range,
   input wire logic positive_gate_supply_ovlo,
   input wire logic thermal_shutdown,
   input wire logic hv_hardware_safe_state,
   // Protection detectors
   input wire logic desaturation_detect,
   input wire logic overcurrent_detect,
   // Pre-driver outputs
   output logic predrive_output_a,
   output logic predrive_output_b,
   // Fault flags and async input level bit
   output logic desaturation_fault_flag,
   output logic overcurrent_fault_flag,
   output logic async_input_level_bit
);
   // Reset release
   logic rst_meta_q;
   logic rst_sync_n_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // Input synchronisation and edge detection
   logic async_s;
   logic async_prev_q;
   wire async_rise;

   ato_sync u_async_sync (
      .clock(clock),
      .rst_n(rst_sync_n_q),
      .din(async_turn_on_input),
      .dout(async_s)
   );

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         async_prev_q <= 1'b0;
      end else begin
         async_prev_q <= async_s;
      end
   end

   // One edge, one event: detection runs on the settled copy only
   assign async_rise = async_s & ~async_prev_q;

   // Control register
   logic [2:0] ctl_q;
   logic [2:0] ctl_d;
   wire wr_control;
   wire desaturation_detect_en;
   wire sense_en;
   wire vh_uvlo_en;

   assign wr_control = reg_write & (reg_addr == ato_pkg::OFS_CONTROL);
   assign ctl_d = wr_control ? reg_wdata[2:0] : ctl_q;
   assign desaturation_detect_en = ctl_q[ato_pkg::CTL_DESATURATION_DETECT_EN_BIT];
   assign sense_en = ctl_q[ato_pkg::CTL_SENSE_EN_BIT];
   assign vh_uvlo_en = ctl_q[ato_pkg::CTL_VH_UVLO_EN_BIT];

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         ctl_q <= ato_pkg::CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Permission for the override.
   // Only HV-side conditions enter here; nothing from the primary
   // side is sampled, so a missing or faulty primary cannot block it.
   wire hv_supplies_ready;
   wire vh_ok;
   wire ato_inhibit;
   wire ato_allowed;

   assign hv_supplies_ready = positive_gate_supply_present & isolated_regulator_supply_present
                              & hv_startup_done;
   assign vh_ok = vh_uvlo_en ? ~positive_gate_supply_uvlo : positive_gate_supply_in_range;
   assign ato_inhibit = positive_gate_supply_ovlo | thermal_shutdown;
   // Negative supply, link and warning faults are left out on purpose; the regulator supply must be present
   assign ato_allowed = hv_supplies_ready & vh_ok & ~ato_inhibit;

   // Protection events
   wire desaturation_detect_event;
   wire oc_event;
   wire prot_event;

   assign desaturation_detect_event = desaturation_detect_en & desaturation_detect;
   assign oc_event = sense_en & overcurrent_detect;
   assign prot_event = desaturation_detect_event | oc_event;

   // Override state machine.
   // Config mode is not an input here: the override runs in every mode.
   ato_pkg::ato_state_t state_q;
   ato_pkg::ato_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ato_pkg::ATO_IDLE: begin
            // Flags are not consulted, so a set flag cannot block turn-on
            if (async_s && ato_allowed && !prot_event) begin
               state_d = ato_pkg::ATO_ON;
            end
         end
         ato_pkg::ATO_ON: begin
            if (prot_event) begin
               state_d = ato_pkg::ATO_TRIP;
            end else if (!async_s || !ato_allowed) begin
               state_d = ato_pkg::ATO_IDLE;
            end
         end
         ato_pkg::ATO_TRIP: begin
            // A held level stays off; a new edge is needed
            if (async_rise && ato_allowed && !prot_event) begin
               state_d = ato_pkg::ATO_ON;
            end else if (!async_s) begin
               state_d = ato_pkg::ATO_IDLE;
            end
         end
         default: begin
            state_d = ato_pkg::ATO_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         state_q <= ato_pkg::ATO_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   wire override_on;
   wire tripped;

   assign override_on = (state_q == ato_pkg::ATO_ON);
   assign tripped = (state_q == ato_pkg::ATO_TRIP);

   // Fault flags: a set in the clearing cycle wins over the clear.
   // The state machine never reads them, so a clear while the input
   // is high leaves the switch exactly where it is.
   logic desaturation_detect_flag_q;
   logic desaturation_detect_flag_d;
   logic oc_flag_q;
   logic oc_flag_d;

   assign desaturation_detect_flag_d = desaturation_detect_event | (desaturation_detect_flag_q & ~flag_clear_operation);
   assign oc_flag_d = oc_event | (oc_flag_q & ~flag_clear_operation);

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         desaturation_detect_flag_q <= 1'b0;
         oc_flag_q <= 1'b0;
      end else begin
         desaturation_detect_flag_q <= desaturation_detect_flag_d;
         oc_flag_q <= oc_flag_d;
      end
   end

   // Re-arm after a flag clear for the normal input path.
   // Pending until the controller shows a safe input pattern with
   // the async input low; until then normal turn-on is held off.
   logic rearm_pend_q;
   logic rearm_pend_d;
   wire rearm_pattern;

   assign rearm_pattern = ~async_s & (~shutdown_input | in_minus | ~in_plus);
   assign rearm_pend_d = flag_clear_operation | (rearm_pend_q & ~rearm_pattern);

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         rearm_pend_q <= 1'b0;
      end else begin
         rearm_pend_q <= rearm_pend_d;
      end
   end

   // Normal input-controlled drive, used when the override is idle
   wire normal_on;

   assign normal_on = shutdown_input & in_plus & ~in_minus & ~desaturation_detect_flag_q & ~oc_flag_q
                      & ~rearm_pend_q & ~prot_event & ~tripped;

   // Output selection: safe state first, then override, then normal.
   // Outputs are registered, so a trip costs one clock of latency.
   logic [1:0] drive_q;
   logic [1:0] drive_d;
   wire switch_on;

   assign switch_on = hv_hardware_safe_state | (override_on & ~prot_event) | normal_on;
   assign drive_d = switch_on ? ato_pkg::DRIVE_SWITCH_ON : ato_pkg::DRIVE_SWITCH_OFF;

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         drive_q <= ato_pkg::DRIVE_SWITCH_OFF;
      end else begin
         drive_q <= drive_d;
      end
   end

   // Level bit register
   logic level_q;

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         level_q <= 1'b0;
      end else begin
         level_q <= async_s;
      end
   end

   // Register read path
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   wire [31:0] rd_control;
   wire [31:0] rd_status_one;
   wire [31:0] rd_status_four;
   wire sel_control;
   wire sel_status_one;
   wire sel_status_four;

   assign rd_control = {29'h0, ctl_q};
   assign rd_status_one = {30'h0, oc_flag_q, desaturation_detect_flag_q};
   assign rd_status_four = {28'h0, rearm_pend_q, tripped, override_on, level_q};
   assign sel_control = (reg_addr == ato_pkg::OFS_CONTROL);
   assign sel_status_one = (reg_addr == ato_pkg::OFS_STATUS_WORD_ONE);
   assign sel_status_four = (reg_addr == ato_pkg::OFS_STATUS_WORD_FOUR);
   // Unmapped addresses read zero; data stands for one cycle only
   assign rdata_d = !reg_read ? 32'h0000_0000 :
                    sel_control ? rd_control :
                    sel_status_one ? rd_status_one :
                    sel_status_four ? rd_status_four : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Output wiring, all from flops
   assign reg_rdata = rdata_q;
   assign predrive_output_a = drive_q[1];
   assign predrive_output_b = drive_q[0];
   assign desaturation_fault_flag = desaturation_detect_flag_q;
   assign overcurrent_fault_flag = oc_flag_q;
   assign async_input_level_bit = level_q;
endmodule
`default_nettype wire

// file: verif/async_turn_on_override_test.sv
// Self-checking bench of the async turn-on override block
`timescale 1ns/10ps
`default_nettype none
module async_turn_on_override_test;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic asy = 1'b0, sd = 1'b0, inp = 1'b0, inm = 1'b0, clr = 1'b0, cfg = 1'b0;
   logic safe = 1'b0, dsd = 1'b0, ocd = 1'b0;
   // Supply within operating range, only consulted with the lockout disabled
   logic rng = 1'b1;
   // Blocking conditions: ovlo, thermal, no supply, no regulator, no start-up, uvlo
   logic [5:0] flt = 6'h00;
   logic [31:0] reg_rdata;
   logic pa, pb, dflag, oflag, lvl, sw_on, split;
   int bad_count = 0, checks_done = 0;
   always #25 clock = ~clock;
   ato_top u_dut (
      .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .async_turn_on_input(asy), .shutdown_input(sd), .in_plus(inp), .in_minus(inm),
      .flag_clear_operation(clr), .config_mode(cfg), .positive_gate_supply_present(~flt[2]),
      .isolated_regulator_supply_present(~flt[3]), .hv_startup_done(~flt[4]), .positive_gate_supply_uvlo(flt[5]),
      .positive_gate_supply_in_range(rng), .positive_gate_supply_ovlo(flt[0]), .thermal_shutdown(flt[1]),
      .hv_hardware_safe_state(safe), .desaturation_detect(dsd), .overcurrent_detect(ocd),
      .predrive_output_a(pa), .predrive_output_b(pb), .desaturation_fault_flag(dflag),
      .overcurrent_fault_flag(oflag), .async_input_level_bit(lvl));
   ato_pushpull_model u_stage (.drive_a(pa), .drive_b(pb), .switch_on(sw_on), .split_drive(split));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic settle(input int n, input logic exp_on);
      cyc(n);
      #1 chk("switch", 32'(sw_on), 32'(exp_on));
      chk("split", 32'(split), 32'h0000_0000);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk("rdata", reg_rdata, e);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      cyc(3000);
      bad_count++;
      conclude();
   end
   initial begin
      cyc(6);
      reset_n <= 1'b1;
      cyc(4);
      rd(ato_pkg::OFS_CONTROL, 32'h0000_0007);
      wr(ato_pkg::OFS_STATUS_WORD_FOUR, 32'hFFFF_FFFF);
      rd(ato_pkg::OFS_STATUS_WORD_FOUR, 32'h0000_0000);
      rd(8'hFC, 32'h0000_0000);
      $display("registers done");
      @(posedge clock) cfg <= 1'b1;
      asy <= 1'b1;
      settle(6, 1'b1);
      chk("level", 32'(lvl), 32'h0000_0001);
      rd(ato_pkg::OFS_STATUS_WORD_FOUR, 32'h0000_0003);
      $display("turn-on done");
      @(posedge clock) dsd <= 1'b1;
      @(posedge clock) dsd <= 1'b0;
      settle(0, 1'b0);
      chk("desaturation_detect flag", 32'(dflag), 32'h0000_0001);
      settle(6, 1'b0);
      rd(ato_pkg::OFS_STATUS_WORD_ONE, 32'h0000_0001);
      @(posedge clock) clr <= 1'b1;
      @(posedge clock) clr <= 1'b0;
      settle(3, 1'b0);
      rd(ato_pkg::OFS_STATUS_WORD_ONE, 32'h0000_0000);
      // Normal path stays blocked until a re-arm combination is seen
      @(posedge clock) asy <= 1'b0;
      sd <= 1'b1;
      inp <= 1'b1;
      settle(6, 1'b0);
      @(posedge clock) inm <= 1'b1;
      @(posedge clock) inm <= 1'b0;
      settle(4, 1'b1);
      @(posedge clock) sd <= 1'b0;
      inp <= 1'b0;
      settle(4, 1'b0);
      @(posedge clock) asy <= 1'b1;
      settle(6, 1'b1);
      @(posedge clock) ocd <= 1'b1;
      @(posedge clock) ocd <= 1'b0;
      settle(0, 1'b0);
      chk("oc flag", 32'(oflag), 32'h0000_0001);
      @(posedge clock) asy <= 1'b0;
      @(posedge clock) asy <= 1'b1;
      settle(6, 1'b1);
      @(posedge clock) clr <= 1'b1;
      @(posedge clock) clr <= 1'b0;
      settle(3, 1'b1);
      chk("oc flag", 32'(oflag), 32'h0000_0000);
      @(posedge clock) asy <= 1'b0;
      settle(6, 1'b0);
      $display("protection done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clock) flt <= 6'h01 << i;
         asy <= 1'b1;
         settle(6, 1'b0);
         @(posedge clock) flt <= 6'h00;
         asy <= 1'b0;
         cyc(3);
      end
      $display("inhibit done");
      // Lockout and desaturation protection off, sense left on
      wr(ato_pkg::OFS_CONTROL, 32'h0000_0002);
      rd(ato_pkg::OFS_CONTROL, 32'h0000_0002);
      @(posedge clock) dsd <= 1'b1;
      @(posedge clock) dsd <= 1'b0;
      settle(2, 1'b0);
      chk("desaturation_detect off flag", 32'(dflag), 32'h0000_0000);
      @(posedge clock) flt <= 6'h20;
      asy <= 1'b1;
      settle(6, 1'b1);
      @(posedge clock) rng <= 1'b0;
      settle(3, 1'b0);
      @(posedge clock) asy <= 1'b0;
      settle(6, 1'b0);
      @(posedge clock) rng <= 1'b1;
      flt <= 6'h00;
      settle(3, 1'b0);
      $display("range gating done");
      @(posedge clock) safe <= 1'b1;
      settle(2, 1'b1);
      @(posedge clock) safe <= 1'b0;
      settle(3, 1'b0);
      $display("safe state done");
      conclude();
   end
endmodule
`default_nettype wire

// file: verif/ato_properties.sv
// Concurrent checks on the async turn-on override ports
`timescale 1ns/10ps
`default_nettype none
module ato_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Inputs of the block
   input wire logic async_turn_on_input,
   input wire logic shutdown_input,
   input wire logic flag_clear_operation,
   input wire logic positive_gate_supply_present,
   input wire logic isolated_regulator_supply_present,
   input wire logic hv_startup_done,
   input wire logic positive_gate_supply_uvlo,
   input wire logic positive_gate_supply_ovlo,
   input wire logic thermal_shutdown,
   input wire logic hv_hardware_safe_state,
   input wire logic desaturation_detect,
   input wire logic overcurrent_detect,
   // Outputs of the block
   input wire logic predrive_output_a,
   input wire logic predrive_output_b,
   input wire logic desaturation_fault_flag,
   input wire logic overcurrent_fault_flag,
   input wire logic async_input_level_bit
);
   logic [2:0] up_q;
   // Internal reset is released two edges late, so judge only once settled
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   wire rdy = up_q == 3'h7;
   // Undervoltage left out: it only blocks while its lockout is enabled
   wire blk = positive_gate_supply_ovlo | thermal_shutdown | ~positive_gate_supply_present
      | ~isolated_regulator_supply_present | ~hv_startup_done;
   wire hit = desaturation_detect | overcurrent_detect;
   wire on = ~predrive_output_a & ~predrive_output_b;
   wire off = predrive_output_a & predrive_output_b;
   wire go = rdy & ~blk & ~positive_gate_supply_uvlo & ~hit & ~hv_hardware_safe_state;
   wire quiet = rdy & ~shutdown_input & ~hv_hardware_safe_state;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_safe_drives_low: assert property (rdy && hv_hardware_safe_state |=> on)
      else $error("safe state did not force both outputs low");
   a_edge_turns_on: assert property (
      $rose(async_turn_on_input) && go ##1 (async_turn_on_input && go)[*3] |=> on)
      else $error("rising edge did not turn the switch on");
   a_trip_turns_off: assert property (
      on && async_turn_on_input && hit && quiet |=> off && (desaturation_fault_flag || !$past(desaturation_detect))
      && (overcurrent_fault_flag || !$past(overcurrent_detect)))
      else $error("protection event did not turn off and flag");
   a_held_no_reon: assert property (
      async_turn_on_input[*5] ##0 (off && quiet && (desaturation_fault_flag || overcurrent_fault_flag)) |=> off)
      else $error("held level turned the switch on again");
   a_blocked_off: assert property ((blk && quiet)[*3] |-> off)
      else $error("switch on while override inhibited");
   a_level_mirror: assert property (rdy |-> async_input_level_bit == $past(async_turn_on_input, 3))
      else $error("level bit does not follow the input");
   a_flag_sticky: assert property (desaturation_fault_flag && !flag_clear_operation |=> desaturation_fault_flag)
      else $error("desaturation flag dropped without clear");
   a_oc_sticky: assert property (overcurrent_fault_flag && !flag_clear_operation |=> overcurrent_fault_flag)
      else $error("overcurrent flag dropped without clear");
   a_clear_keeps_on: assert property (flag_clear_operation && on && async_turn_on_input && go |=> on)
      else $error("flag clear changed the switch state");
   c_turn_on: cover property ($fell(predrive_output_a));
   c_desaturation_detect_trip: cover property ($rose(desaturation_fault_flag));
   c_oc_trip: cover property ($rose(overcurrent_fault_flag));
endmodule
bind ato_top ato_properties u_props (
   .clock(clock),
   .reset_n(reset_n),
   .async_turn_on_input(async_turn_on_input),
   .shutdown_input(shutdown_input),
   .flag_clear_operation(flag_clear_operation),
   .positive_gate_supply_present(positive_gate_supply_present),
   .isolated_regulator_supply_present(isolated_regulator_supply_present),
   .hv_startup_done(hv_startup_done),
   .positive_gate_supply_uvlo(positive_gate_supply_uvlo),
   .positive_gate_supply_ovlo(positive_gate_supply_ovlo),
   .thermal_shutdown(thermal_shutdown),
   .hv_hardware_safe_state(hv_hardware_safe_state),
   .desaturation_detect(desaturation_detect),
   .overcurrent_detect(overcurrent_detect),
   .predrive_output_a(predrive_output_a),
   .predrive_output_b(predrive_output_b),
   .desaturation_fault_flag(desaturation_fault_flag),
   .overcurrent_fault_flag(overcurrent_fault_flag),
   .async_input_level_bit(async_input_level_bit)
);
`default_nettype wire

// file: verif/ato_pushpull_model.sv
// Behavioural model of the external push-pull stage and power switch
`timescale 1ns/10ps
`default_nettype none
module ato_pushpull_model (
   // Pre-driver levels
   input wire logic drive_a,
   input wire logic drive_b,
   // Switch state
   output logic switch_on,
   output logic split_drive
);
   // Both low conducts the upper device; a split level would crowbar the stage
   assign switch_on = ~drive_a & ~drive_b;
   assign split_drive = drive_a ^ drive_b;
endmodule
`default_nettype wire
